//--- design/gep_top.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "gep_defs.svh"

module gep_top
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  p_pin_in,
   output logic      [7:0]  p_pull_up_en,
   output logic      [7:0]  p_pull_dn_en,
   output logic             p_irq,
   input  wire logic [1:0]  j_pin_in,
   output logic      [1:0]  j_pin_out,
   output logic      [1:0]  j_pin_oe_n,
   output logic      [1:0]  j_drive_reduce,
   output logic      [1:0]  j_pull_en
);

   gep_pkg::gep_state_t st_reg;
   gep_pkg::gep_state_t st_next;

   logic [9:0] pins_sync;
   logic [7:0] p_sync;
   logic [1:0] j_sync;
   logic [5:0] idx;
   logic       setup;
   logic       access;
   logic       wr;
   logic       aligned;
   logic [7:0] p_edge;
   logic [7:0] p_clear;
   logic [1:0] j_data_view;

   // ----------------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------------
   // Both ports share one synchroniser; readback lags pins by two cycles
   gep_sync u_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({j_pin_in, p_pin_in}),
      .q       (pins_sync)
   );                                                   // [RULE15] [RULE11]

   assign p_sync = pins_sync[7:0];
   assign j_sync = pins_sync[9:8];

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   assign idx    = paddr[`GEP_IDX_MSB:`GEP_IDX_LSB];
   assign setup  = psel && !penable;
   assign access = psel && penable && st_reg.pready;
   assign wr     = access && pwrite && aligned;

   // A misaligned address is refused, so its write must not land either
   assign aligned = paddr[`GEP_ALIGN_MSB:`GEP_ALIGN_LSB] == `GEP_ALIGNED;

   // Active edge per pin: changed and now equal to the polarity bit
   assign p_edge = (p_sync ^ st_reg.p_prev) & ~(p_sync ^ st_reg.p_pol); // [RULE1] [RULE2]

   // Clear mask only on a write to the flag register
   assign p_clear = (wr && idx == `GEP_IDX_P_FLAGS) ? pwdata[7:0] : `GEP_RST_P8;

   // Output pins read back their stored value, inputs their level
   assign j_data_view = (st_reg.j_dir & st_reg.j_data)
                      | (~st_reg.j_dir & j_sync);         // [RULE8] [RULE10]

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      st_next        = st_reg;
      st_next.p_prev = p_sync;

      // Set wins over clear so a coincident edge is not lost
      st_next.p_flags = (st_reg.p_flags & ~p_clear) | p_edge; // [RULE5] [RULE6] [RULE16]

      // Register writes at the access edge; pin-input register ignores them
      if (wr)
      begin
         case (idx)
            `GEP_IDX_P_DIR:      st_next.p_dir      = pwdata[7:0];
            `GEP_IDX_P_PULL_EN:  st_next.p_pull_en  = pwdata[7:0];
            `GEP_IDX_P_POL:      st_next.p_pol      = pwdata[7:0];
            `GEP_IDX_P_IRQ_EN:   st_next.p_irq_en   = pwdata[7:0];
            `GEP_IDX_J_WIRED_OR: st_next.j_wired_or = pwdata[`GEP_J_MSB:`GEP_J_LSB];
            `GEP_IDX_J_DATA:     st_next.j_data     = pwdata[`GEP_J_MSB:`GEP_J_LSB];
            `GEP_IDX_J_DIR:      st_next.j_dir      = pwdata[`GEP_J_MSB:`GEP_J_LSB];
            `GEP_IDX_J_DRIVE:    st_next.j_drive    = pwdata[`GEP_J_MSB:`GEP_J_LSB];
            `GEP_IDX_J_PULL_EN:  st_next.j_pull_en  = pwdata[`GEP_J_MSB:`GEP_J_LSB];
            default:             st_next.j_data     = st_reg.j_data;  // [RULE9]
         endcase
      end

      // Answer one cycle after setup: zero-wait access phase
      st_next.pready  = setup;
      st_next.pslverr = 1'b0;
      st_next.prdata  = `GEP_RST_WORD;
      if (setup)
      begin
         case (idx)
            `GEP_IDX_P_DIR:      st_next.prdata[7:0] = st_reg.p_dir;
            `GEP_IDX_P_PULL_EN:  st_next.prdata[7:0] = st_reg.p_pull_en;
            `GEP_IDX_P_POL:      st_next.prdata[7:0] = st_reg.p_pol;
            `GEP_IDX_P_IRQ_EN:   st_next.prdata[7:0] = st_reg.p_irq_en;
            `GEP_IDX_P_FLAGS:    st_next.prdata[7:0] = st_reg.p_flags;
            `GEP_IDX_J_WIRED_OR:
               st_next.prdata[`GEP_J_MSB:`GEP_J_LSB] = st_reg.j_wired_or;
            `GEP_IDX_J_DATA:
               st_next.prdata[`GEP_J_MSB:`GEP_J_LSB] = j_data_view;   // [RULE8]
            `GEP_IDX_J_PINS:
               st_next.prdata[`GEP_J_MSB:`GEP_J_LSB] = j_sync;        // [RULE9]
            `GEP_IDX_J_DIR:
               st_next.prdata[`GEP_J_MSB:`GEP_J_LSB] = st_reg.j_dir;
            `GEP_IDX_J_DRIVE:
               st_next.prdata[`GEP_J_MSB:`GEP_J_LSB] = st_reg.j_drive;
            `GEP_IDX_J_PULL_EN:
               st_next.prdata[`GEP_J_MSB:`GEP_J_LSB] = st_reg.j_pull_en;
            default:
               st_next.pslverr = 1'b1;
         endcase
         // Misaligned addresses are treated as unmapped
         if (!aligned)
         begin
            st_next.pslverr = 1'b1;
            st_next.prdata  = `GEP_RST_WORD;
         end
      end

      // Outputs follow the next state so they match registers each cycle
      st_next.irq     = |(st_next.p_flags & st_next.p_irq_en);        // [RULE4] [RULE7]
      st_next.pull_up = st_next.p_pull_en & ~st_next.p_pol & ~st_next.p_dir; // [RULE1] [RULE3]
      st_next.pull_dn = st_next.p_pull_en & st_next.p_pol & ~st_next.p_dir;  // [RULE2] [RULE3]
      st_next.j_out   = st_next.j_data;
      // Wired-or outputs release the pin for a one
      st_next.j_oe_n  = ~(st_next.j_dir & (~st_next.j_wired_or | ~st_next.j_data)); // [RULE10]
      st_next.j_reduce = st_next.j_dir & st_next.j_drive;              // [RULE12]
      st_next.j_pull  = st_next.j_pull_en & (~st_next.j_dir | st_next.j_wired_or); // [RULE13]
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   // Pull enables clear at reset so no pull device is active
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg           <= '0;                                   // [RULE14]
         st_reg.j_oe_n    <= `GEP_RST_J_OE_N;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign prdata         = st_reg.prdata;
   assign pready         = st_reg.pready;
   assign pslverr        = st_reg.pslverr;
   assign p_pull_up_en   = st_reg.pull_up;
   assign p_pull_dn_en   = st_reg.pull_dn;
   assign p_irq          = st_reg.irq;
   assign j_pin_out      = st_reg.j_out;
   assign j_pin_oe_n     = st_reg.j_oe_n;
   assign j_drive_reduce = st_reg.j_reduce;
   assign j_pull_en      = st_reg.j_pull;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_setup(logic [5:0] a, logic w);
      psel && !penable && idx == a && pwrite == w && aligned;
   endsequence

   sequence s_access;
      psel && penable && pready;
   endsequence

   sequence s_write(logic [5:0] a);
      s_setup(a, 1'b1) ##1 s_access;
   endsequence

   sequence s_misaligned;
      psel && !penable && !aligned;
   endsequence

   // Each edge leaves its flag set one cycle later, even against a clear
   chk_flag_edge_set: assert property (                            // [RULE5] [RULE16]
      p_edge != 8'h00 |=> (st_reg.p_flags & $past(p_edge)) == $past(p_edge))
      else $error("active edge did not set its flag");

   // A written one clears a flag that sees no new edge
   chk_flag_w1c: assert property (                                 // [RULE6]
      (s_setup(`GEP_IDX_P_FLAGS, 1'b1) ##1 s_access)
      |=> ((st_reg.p_flags & $past(pwdata[7:0]) & ~$past(p_edge)) == 8'h00)
      && ((st_reg.p_flags & ~$past(pwdata[7:0])) == (($past(st_reg.p_flags)
         | $past(p_edge)) & ~$past(pwdata[7:0]))))
      else $error("flag clear by writing one misbehaved");

   // Interrupt output tracks enabled flags
   chk_irq_gate: assert property (                                 // [RULE4] [RULE7]
      p_irq == |(st_reg.p_flags & st_reg.p_irq_en))
      else $error("interrupt level disagrees with flags and enables");

   // Port P pull selection per polarity and direction
   chk_pull_select: assert property (                              // [RULE1] [RULE2] [RULE3]
      p_pull_up_en == (st_reg.p_pull_en & ~st_reg.p_pol & ~st_reg.p_dir)
      && p_pull_dn_en == (st_reg.p_pull_en & st_reg.p_pol & ~st_reg.p_dir)
      && (p_pull_up_en & p_pull_dn_en) == 8'h00)
      else $error("port P pull selection wrong");

   // No port P pull device just after reset
   chk_pull_reset: assert property (                               // [RULE14]
      $rose(presetn) |-> st_reg.p_pull_en == 8'h00 && p_pull_up_en == 8'h00)
      else $error("port P pull enabled after reset");

   // Synchronised pins lag the pads by two edges
   // Skipped for the two edges after a release, as the stages were held clear
   chk_sync_latency: assert property (                             // [RULE15] [RULE11]
      ##2 $past(presetn, 2) |-> pins_sync == $past({j_pin_in, p_pin_in}, 2))
      else $error("synchroniser latency is not two cycles");

   // Port J data read returns the mixed view sampled at setup
   chk_jdata_read: assert property (                               // [RULE8] [RULE10]
      s_setup(`GEP_IDX_J_DATA, 1'b0) |=> pready && !pslverr
      && prdata[`GEP_J_MSB:`GEP_J_LSB]
         == $past((st_reg.j_dir & st_reg.j_data) | (~st_reg.j_dir & j_sync)))
      else $error("port J data readback wrong");

   // A write to the pin-input register leaves port J data, direction and pull enable unchanged
   chk_jpins_ro: assert property (                                 // [RULE9]
      (s_setup(`GEP_IDX_J_PINS, 1'b1) ##1 s_access)
      |=> $stable(st_reg.j_data) && $stable(st_reg.j_dir) && $stable(st_reg.j_pull_en))
      else $error("write to pin-input register had an effect");

   // Reduced drive only on outputs; pull only on inputs or wired-or
   chk_j_drive_pull: assert property (                             // [RULE12] [RULE13]
      j_drive_reduce == (st_reg.j_dir & st_reg.j_drive)
      && j_pull_en == (st_reg.j_pull_en & (~st_reg.j_dir | st_reg.j_wired_or)))
      else $error("port J drive or pull gating wrong");

   // ----------------------------------------------------------------------
   // Bus checks
   // ----------------------------------------------------------------------
   // Every setup is answered in the very next cycle
   chk_ready_next: assert property (
      psel && !penable |=> pready)
      else $error("no ready in the cycle after setup");

   // Ready stands one cycle so a master never sees a stale answer
   chk_ready_single: assert property (
      pready |=> !pready)
      else $error("ready stood longer than one cycle");

   // Read data and error stay quiet outside the answer cycle
   chk_idle_quiet: assert property (
      !pready |-> prdata == `GEP_RST_WORD && !pslverr)
      else $error("read data or error outside the answer cycle");

   // A misaligned address is refused with an error and empty data
   chk_misaligned_err: assert property (
      s_misaligned |=> pslverr && prdata == `GEP_RST_WORD)
      else $error("misaligned address not refused");

   // A misaligned write must not change polarity, interrupt enable, port P pull enable or port J direction
   chk_misaligned_drop: assert property (
      s_misaligned ##1 (psel && penable && pready && pwrite)
      |=> $stable(st_reg.p_pol) && $stable(st_reg.p_irq_en)
      && $stable(st_reg.p_pull_en) && $stable(st_reg.j_dir))
      else $error("misaligned write changed a register");

   // ----------------------------------------------------------------------
   // Port P checks
   // ----------------------------------------------------------------------
   // Rising-active pins flag every rise of the synchronised level
   chk_rise_flag: assert property (                                 // [RULE2] [RULE5]
      1'b1 |=> (st_reg.p_flags & $past(p_sync & ~st_reg.p_prev & st_reg.p_pol))
      == $past(p_sync & ~st_reg.p_prev & st_reg.p_pol))
      else $error("rising edge did not set its flag");

   // Falling-active pins flag every fall of the synchronised level
   chk_fall_flag: assert property (                                 // [RULE1] [RULE5]
      1'b1 |=> (st_reg.p_flags & $past(~p_sync & st_reg.p_prev & ~st_reg.p_pol))
      == $past(~p_sync & st_reg.p_prev & ~st_reg.p_pol))
      else $error("falling edge did not set its flag");

   // A flag only appears after an active edge
   chk_flag_cause: assert property (                                // [RULE5]
      1'b1 |=> (st_reg.p_flags & ~$past(st_reg.p_flags) & ~$past(p_edge)) == `GEP_RST_P8)
      else $error("flag set without an active edge");

   // Without a register write no flag is lost
   chk_flag_sticky: assert property (                               // [RULE6]
      !wr |=> (st_reg.p_flags & $past(st_reg.p_flags)) == $past(st_reg.p_flags))
      else $error("flag dropped without a clear");

   // Masked flags never raise the request
   chk_irq_masked: assert property (                                // [RULE4]
      (st_reg.p_flags & st_reg.p_irq_en) == `GEP_RST_P8 |-> !p_irq)
      else $error("masked flag raised the interrupt");

   // A polarity write lands at its access edge
   chk_pol_write: assert property (                                 // [RULE1] [RULE2]
      s_write(`GEP_IDX_P_POL) |=> st_reg.p_pol == $past(pwdata[7:0]))
      else $error("polarity write did not land");

   // ----------------------------------------------------------------------
   // Port J checks
   // ----------------------------------------------------------------------
   // Pin-input register reads the synchronised levels whatever the direction
   chk_jpins_read: assert property (                                // [RULE9] [RULE11]
      s_setup(`GEP_IDX_J_PINS, 1'b0)
      |=> prdata[`GEP_J_MSB:`GEP_J_LSB] == $past(j_sync) && !pslverr)
      else $error("pin-input readback wrong");

   // Only outputs may drive; push-pull outputs always drive
   chk_j_oe_dir: assert property (                                  // [RULE10]
      (~j_pin_oe_n & ~st_reg.j_dir) == `GEP_RST_J2
      && (st_reg.j_dir & ~st_reg.j_wired_or & j_pin_oe_n) == `GEP_RST_J2)
      else $error("port J output enable disagrees with direction");

   // The output pins show the stored data
   chk_j_out_data: assert property (                                // [RULE8]
      j_pin_out == st_reg.j_data)
      else $error("port J output value differs from stored data");

   // Reduced drive never applies to an input pin
   chk_j_reduce_in: assert property (                               // [RULE12]
      (j_drive_reduce & ~st_reg.j_dir) == `GEP_RST_J2)
      else $error("reduced drive on an input pin");

endmodule

`default_nettype wire

//--- design/gep_defs.svh
// Contract
// RULE1 - Polarity bit 0 selects falling edge as active and a pull-up device.
// RULE2 - Polarity bit 1 selects rising edge as active and a pull-down device.
// RULE3 - Port P pull device connects only when pull-enabled and the pin is an input.
// RULE4 - Each port P pin has an interrupt enable; 0 masks, 1 allows.
// RULE5 - An active edge on a port P pin sets that pin's flag.
// RULE6 - Writing 1 clears a port P flag, writing 0 leaves it; 0 means none pending.
// RULE7 - Interrupt request is high while any flag and its enable are both set.
// RULE8 - Port J data reads return stored value for outputs, pin level for inputs.
// RULE9 - Port J pin-input register always returns pin levels and ignores writes.
// RULE10 - Only port J pins 7 and 6 exist; direction 0 input, 1 output.
// RULE11 - Readback after a direction change may lag two bus cycles from synchronisation.
// RULE12 - Port J drive-select: 0 full, 1 about one third; ignored for inputs.
// RULE13 - Port J pull enable acts only for inputs or wired-or outputs.
// RULE14 - After reset the port P pull enables are cleared.
// RULE15 - Port P inputs pass two synchroniser stages before edge detection.
// RULE16 - An edge in the same cycle as its flag clear keeps the flag set.
`ifndef GEP_DEFS_SVH
`define GEP_DEFS_SVH

// -------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// -------------------------------------------------------------------------
`define GEP_IDX_P_DIR      6'h1a
`define GEP_IDX_P_PULL_EN  6'h1c
`define GEP_IDX_P_POL      6'h1d
`define GEP_IDX_P_IRQ_EN   6'h1e
`define GEP_IDX_P_FLAGS    6'h1f
`define GEP_IDX_J_WIRED_OR 6'h27
`define GEP_IDX_J_DATA     6'h28
`define GEP_IDX_J_PINS     6'h29
`define GEP_IDX_J_DIR      6'h2a
`define GEP_IDX_J_DRIVE    6'h2b
`define GEP_IDX_J_PULL_EN  6'h2c

// -------------------------------------------------------------------------
// Field positions and reset values
// -------------------------------------------------------------------------
`define GEP_J_MSB          7
`define GEP_J_LSB          6
`define GEP_IDX_MSB        7
`define GEP_IDX_LSB        2
`define GEP_ALIGN_MSB      1
`define GEP_ALIGN_LSB      0
`define GEP_ALIGNED        2'h0
`define GEP_RST_J_OE_N     2'h3
`define GEP_RST_P8         8'h00
`define GEP_RST_J2         2'h0
`define GEP_RST_WORD       32'h0000_0000
`define GEP_SYNC_STAGES    2

`endif

//--- design/gep_pkg.sv
`default_nettype none

package gep_pkg;

   // ----------------------------------------------------------------------
   // State of the synchroniser
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [9:0] stage1;
      logic [9:0] stage2;
   } gep_sync_state_t;

   // ----------------------------------------------------------------------
   // State of the port block
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  p_pol;
      logic [7:0]  p_irq_en;
      logic [7:0]  p_flags;
      logic [7:0]  p_pull_en;
      logic [7:0]  p_dir;
      logic [7:0]  p_prev;
      logic [1:0]  j_data;
      logic [1:0]  j_dir;
      logic [1:0]  j_drive;
      logic [1:0]  j_pull_en;
      logic [1:0]  j_wired_or;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        irq;
      logic [7:0]  pull_up;
      logic [7:0]  pull_dn;
      logic [1:0]  j_out;
      logic [1:0]  j_oe_n;
      logic [1:0]  j_reduce;
      logic [1:0]  j_pull;
   } gep_state_t;

endpackage

`default_nettype wire

//--- design/gep_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for the ten pin inputs; stage1 feeds only stage2
module gep_sync
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [9:0] d,
   output logic      [9:0] q
);

   gep_pkg::gep_sync_state_t sync_reg;
   gep_pkg::gep_sync_state_t sync_next;

   // ----------------------------------------------------------------------
   // Stage shifting
   // ----------------------------------------------------------------------
   always_comb
   begin
      sync_next        = sync_reg;
      sync_next.stage1 = d;
      sync_next.stage2 = sync_reg.stage1;
   end

   // Register stage, cleared under reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_reg <= '0;
      end
      else
      begin
         sync_reg <= sync_next;
      end
   end

   assign q = sync_reg.stage2;

endmodule

`default_nettype wire

//--- testbench/gep_board.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Board model
// ----------------------------------------------------------------------
module gep_board
(
   input  wire logic [7:0] ext_p,
   input  wire logic [1:0] ext_j,
   input  wire logic [1:0] j_pin_out,
   input  wire logic [1:0] j_pin_oe_n,
   output logic      [7:0] p_pin_in,
   output logic      [1:0] j_pin_in
);
   // Port P lines are always driven from the board side here
   assign p_pin_in = ext_p;
   // A driven port J line shows the block's level, a released one the board's
   assign j_pin_in = (~j_pin_oe_n & j_pin_out) | (j_pin_oe_n & ext_j);
endmodule

`default_nettype wire

//--- testbench/gpio_edge_irq_ports_tb.sv
`timescale 1ns/100ps
`default_nettype none

module gpio_edge_irq_ports_tb;
   // ----------------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------------
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  p_pin_in;
   logic [7:0]  p_pull_up_en;
   logic [7:0]  p_pull_dn_en;
   logic        p_irq;
   logic [1:0]  j_pin_in;
   logic [1:0]  j_pin_out;
   logic [1:0]  j_pin_oe_n;
   logic [1:0]  j_drive_reduce;
   logic [1:0]  j_pull_en;
   logic [7:0]  ext_p;
   logic [1:0]  ext_j;
   logic [31:0] rd;
   logic        er;
   int          errors;
   int          check_count;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} gep_row_t;
   gep_row_t    rows [11];

   gep_top u_gep_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .p_pin_in(p_pin_in), .p_pull_up_en(p_pull_up_en),
      .p_pull_dn_en(p_pull_dn_en), .p_irq(p_irq), .j_pin_in(j_pin_in),
      .j_pin_out(j_pin_out), .j_pin_oe_n(j_pin_oe_n), .j_drive_reduce(j_drive_reduce),
      .j_pull_en(j_pull_en));
   gep_board u_gep_board (.ext_p(ext_p), .ext_j(ext_j), .j_pin_out(j_pin_out),
      .j_pin_oe_n(j_pin_oe_n), .p_pin_in(p_pin_in), .j_pin_in(j_pin_in));

   // Free-running bus clock
   initial pclk = 1'b0;
   always #5 pclk = ~pclk;

   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic stop_test;
      if (errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask

   // One bus transfer; values read at an edge are those just before it
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         errors++;
         stop_test();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      errors = 0;
      check_count = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ext_p = 8'h00;
      ext_j = 2'h0;
      rows = '{'{8'h74, 32'ha5, 32'ha5, 1'b0}, '{8'h78, 32'h5a, 32'h5a, 1'b0},
               '{8'h70, 32'hff, 32'hff, 1'b0}, '{8'h68, 32'h0f, 32'h0f, 1'b0},
               '{8'hac, 32'hffffffff, 32'hc0, 1'b0}, '{8'hb0, 32'hffffffff, 32'hc0, 1'b0},
               '{8'ha8, 32'hffffffff, 32'hc0, 1'b0}, '{8'h9c, 32'h0, 32'h0, 1'b0},
               '{8'ha0, 32'h80, 32'h80, 1'b0}, '{8'h04, 32'h1, 32'h0, 1'b1},
               '{8'h75, 32'h1, 32'h0, 1'b1}};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      chk("pull up", p_pull_up_en, 32'h0);
      chk("j oe", j_pin_oe_n, 32'h3);
      apb(1'b0, 8'h70, 32'h0);
      chk("p pull en", rd, 32'h0);
      // Write then read back every row, unmapped places included
      foreach (rows[i])
      begin
         apb(1'b1, rows[i].a, rows[i].w);
         apb(1'b0, rows[i].a, 32'h0);
         chk("reg data", rd, rows[i].r);
         chk("reg err", er, rows[i].e);
      end
      cyc(2);
      chk("pull up", p_pull_up_en, 32'h50);
      chk("pull dn", p_pull_dn_en, 32'ha0);
      chk("j out", {j_pin_out, j_pin_oe_n}, 32'h8);
      chk("j drive", j_drive_reduce, 32'h3);
      chk("j pull", j_pull_en, 32'h0);
      // Port J back to inputs, board drives pin 6 high
      ext_j <= 2'b01;
      apb(1'b1, 8'ha8, 32'h0);
      cyc(3);
      chk("j in", {j_pin_oe_n, j_drive_reduce, j_pull_en}, 32'h33);
      apb(1'b0, 8'ha0, 32'h0);
      chk("j data", rd, 32'h40);
      apb(1'b1, 8'ha4, 32'hc0);
      apb(1'b0, 8'ha4, 32'h0);
      chk("j pins", {er, rd[30:0]}, 32'h40);
      // Wired-or outputs: a one is released, a zero is driven
      apb(1'b1, 8'h9c, 32'hc0);
      apb(1'b1, 8'ha8, 32'hc0);
      cyc(3);
      chk("j wired", {j_pin_oe_n, j_pull_en}, 32'hb);
      apb(1'b0, 8'ha4, 32'h0);
      chk("j pins", rd, 32'h0);
      apb(1'b0, 8'ha0, 32'h0);
      chk("j data", rd, 32'h80);
      // Port P edges: pin 0 rising-active, pin 1 falling-active
      ext_p <= 8'h03;
      cyc(6);
      apb(1'b0, 8'h7c, 32'h0);
      chk("flags", rd, 32'h01);
      chk("irq", p_irq, 32'h0);
      apb(1'b1, 8'h78, 32'h5b);
      cyc(2);
      chk("irq", p_irq, 32'h1);
      apb(1'b1, 8'h78, 32'h5a);
      cyc(2);
      chk("irq", p_irq, 32'h0);
      ext_p <= 8'h01;
      cyc(6);
      apb(1'b0, 8'h7c, 32'h0);
      chk("flags", rd, 32'h03);
      chk("irq", p_irq, 32'h1);
      apb(1'b1, 8'h7c, 32'h01);
      apb(1'b0, 8'h7c, 32'h0);
      chk("flags", rd, 32'h02);
      apb(1'b1, 8'h7c, 32'h02);
      cyc(2);
      chk("irq", p_irq, 32'h0);
      // Edge lands on the very edge that clears its flag
      ext_p <= 8'h00;
      cyc(4);
      ext_p <= 8'h01;
      apb(1'b1, 8'h7c, 32'h01);
      apb(1'b0, 8'h7c, 32'h0);
      chk("flags", rd, 32'h01);
      // Second reset in mid-run
      presetn <= 1'b0;
      cyc(2);
      presetn <= 1'b1;
      apb(1'b0, 8'h70, 32'h0);
      chk("p pull en", rd, 32'h0);
      chk("pull up", p_pull_up_en, 32'h0);
      stop_test();
   end
endmodule

`default_nettype wire
